// >>> inc/hwstack_pkg.sv
// Shared constants and types for the hardware stack cache
package hwstack_pkg;

    localparam int unsigned XLEN = 32;
    localparam int unsigned CSR_AW = 12;

    // CSR numbers in the custom read/write space
    localparam logic [CSR_AW-1:0] CSR_STACK_CONTROL      = 12'h7c0;
    localparam logic [CSR_AW-1:0] CSR_STACK_REGION_START = 12'h7c1;
    localparam logic [CSR_AW-1:0] CSR_STACK_TOP_POINTER  = 12'h7c2;
    localparam logic [CSR_AW-1:0] CSR_STACK_REGION_LIMIT = 12'h7c3;
    localparam logic [CSR_AW-1:0] CSR_PUSH_PORT          = 12'h7c4;
    localparam logic [CSR_AW-1:0] CSR_POP_PORT           = 12'h7c5;

    // Control register layout
    localparam int unsigned CTRL_EN_BIT   = 0;
    localparam int unsigned CTRL_FILL_LSB = 8;
    localparam int unsigned CTRL_FILL_MSB = 31;

    // Values after reset
    localparam logic [XLEN-1:0] RESET_ADDR = 32'h0000_0000;
    localparam logic [XLEN-1:0] RESET_DATA = 32'h0000_0000;

    // Byte step between stack words
    localparam logic [XLEN-1:0] WORD_BYTES = 32'h0000_0004;

    typedef enum logic [2:0] {
        SEL_NONE    = 3'b000,
        SEL_CONTROL = 3'b001,
        SEL_START   = 3'b010,
        SEL_POINTER = 3'b011,
        SEL_LIMIT   = 3'b100,
        SEL_PUSH    = 3'b101,
        SEL_POP     = 3'b110
    } csr_sel_type;

    typedef enum logic [1:0] {
        XFER_IDLE   = 2'b00,
        XFER_SPILL  = 2'b01,
        XFER_REFILL = 2'b10
    } xfer_state_type;

    // Request from the core's CSR unit
    typedef struct packed {
        logic              write;
        logic [CSR_AW-1:0] addr;
        logic [XLEN-1:0]   wdata;
    } csr_req_type;

    // One beat towards main memory
    typedef struct packed {
        logic            write;
        logic [XLEN-1:0] addr;
        logic [XLEN-1:0] wdata;
        logic            last;
    } mem_req_type;

endpackage : hwstack_pkg

// >>> logic/csr_hardware_stack_cache.sv
// Hardware stack cache: CSR logic, top-of-stack cache, memory transfers, control
// Function
// [RULE1] Writing the push port places the data as the new top element.
// [RULE2] Reading the pop port returns the top element and removes it.
// [RULE3] Control bit 0 enables; clearing it flushes all cached content to memory.
// [RULE4] Control upper field reports cache fill; writes to it are ignored.
// [RULE5] Region start CSR holds the address where the stack region begins.
// [RULE6] Top pointer CSR holds current memory top address, readable and writable.
// [RULE7] Region limit CSR holds the address where the stack region ends.
// [RULE8] Top elements live in a local cache; memory moves run independently.
// [RULE9] An empty cache is refilled with the next elements from memory.
// [RULE10] A full cache stores elements out to memory to make room; here only while a whole burst fits before the region limit.
// [RULE11] Cache-memory transfers are bursts sized by a synthesis parameter.
// [RULE12] Cache capacity is set by a synthesis parameter.
// [RULE13] Configuration and runtime CSR accesses may take wait states.
// [RULE14] At most one memory transaction is outstanding at any time.
// [RULE15] The block computes all stack memory addresses itself.
// [RULE16] Software sets start, pointer, limit, then writes 1 to control.
// [RULE17] Context switch: disable, swap start/pointer/limit, enable again.
// [RULE18] Pop on empty or push on full stalls until the pending transfer ends.
`timescale 1ns/1ps

module csr_hardware_stack_cache
    import hwstack_pkg::*;
#(
    parameter int unsigned STACK_SIZE       = 16,
    parameter int unsigned STACK_BURST_SIZE = 4
)(
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        resetn,
    // CSR port from the core
    input  wire logic        csr_valid,
    input  wire csr_req_type csr_req,
    output logic             csr_ready,
    output logic             csr_error,
    output logic [XLEN-1:0]  csr_rdata,
    // Memory port
    output logic             mem_valid,
    output mem_req_type      mem_req,
    input  wire logic        mem_ack,
    input  wire logic [XLEN-1:0] mem_rdata
);

    localparam int unsigned IW = $clog2(STACK_SIZE);
    localparam int unsigned FW = $clog2(STACK_SIZE + 1);
    localparam int unsigned BW = $clog2(STACK_BURST_SIZE + 1);
    localparam logic [FW-1:0] FULL_FILL = FW'(STACK_SIZE);
    localparam logic [BW-1:0] BURST_CNT = BW'(STACK_BURST_SIZE);

    function automatic csr_sel_type csr_decode(input logic [CSR_AW-1:0] a);
        case (a)
            CSR_STACK_CONTROL:      csr_decode = SEL_CONTROL;
            CSR_STACK_REGION_START: csr_decode = SEL_START;
            CSR_STACK_TOP_POINTER:  csr_decode = SEL_POINTER;
            CSR_STACK_REGION_LIMIT: csr_decode = SEL_LIMIT;
            CSR_PUSH_PORT:          csr_decode = SEL_PUSH;
            CSR_POP_PORT:           csr_decode = SEL_POP;
            default:                csr_decode = SEL_NONE;
        endcase
    endfunction : csr_decode

    function automatic logic [XLEN-1:0] bytes_of(input logic [BW-1:0] n);
        bytes_of = XLEN'(n) << 2;
    endfunction : bytes_of

    ////////////////////////////////////////////////////////////////////////////
    // State

    logic [XLEN-1:0]  cache_mem [STACK_SIZE];
    logic             ctrl_en_reg;
    logic             flush_reg;
    logic [XLEN-1:0]  start_reg;
    logic [XLEN-1:0]  pointer_reg;
    logic [XLEN-1:0]  limit_reg;
    logic [FW-1:0]    fill_reg;
    logic [FW-1:0]    fill_next;
    logic [IW-1:0]    bot_reg;
    xfer_state_type   state_reg;
    logic [BW-1:0]    beat_reg;
    logic [BW-1:0]    count_reg;
    logic             ack_reg;
    logic             err_reg;
    logic [XLEN-1:0]  rdata_reg;
    logic             mem_valid_reg;
    mem_req_type      mem_req_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Decisions

    csr_sel_type      sel;
    logic [IW-1:0]    top_idx;
    logic [IW-1:0]    push_idx;
    logic [XLEN-1:0]  words_below;
    logic [XLEN-1:0]  words_room;
    logic             spill_start;
    logic             refill_start;
    logic [BW-1:0]    start_count;
    logic             xfer_last;
    logic             spill_done;
    logic             refill_done;
    logic             cfg_busy;
    logic             req_new;
    logic             do_push;
    logic             do_pop;
    logic             underflow;
    logic             accept;

    assign sel      = csr_decode(csr_req.addr);
    assign top_idx  = bot_reg + IW'(fill_reg) - IW'(1);
    assign push_idx = bot_reg + IW'(fill_reg);
    assign words_below = (pointer_reg - start_reg) >> 2;
    assign words_room  = (limit_reg >= pointer_reg) ? ((limit_reg - pointer_reg) >> 2) : '0;

    // Spill on full (bounded by the region limit) or while flushing
    assign spill_start = (state_reg == XFER_IDLE)
                       && ((ctrl_en_reg && fill_reg == FULL_FILL
                            && words_room >= XLEN'(STACK_BURST_SIZE))       // see [RULE10]
                           || (flush_reg && fill_reg != '0));               // see [RULE3]
    assign refill_start = (state_reg == XFER_IDLE) && !spill_start && ctrl_en_reg
                        && !flush_reg && fill_reg == '0
                        && words_below != '0;                               // see [RULE9]

    always_comb
    begin
        start_count = BURST_CNT;                                            // see [RULE11]
        if (spill_start && flush_reg && fill_reg < FW'(STACK_BURST_SIZE))
        begin
            start_count = BW'(fill_reg);
        end
        else if (refill_start && words_below < XLEN'(STACK_BURST_SIZE))
        begin
            start_count = BW'(words_below);
        end
    end

    assign xfer_last   = mem_ack && mem_valid_reg && (beat_reg == count_reg - BW'(1));
    assign spill_done  = xfer_last && (state_reg == XFER_SPILL);
    assign refill_done = xfer_last && (state_reg == XFER_REFILL);

    // Configuration waits while a transfer or flush is under way
    assign cfg_busy = (state_reg != XFER_IDLE) || flush_reg
                    || spill_start || refill_start;                         // see [RULE13]

    assign req_new   = csr_valid && !ack_reg;
    assign underflow = (fill_reg == '0) && (state_reg == XFER_IDLE)
                     && !refill_start && words_below == '0;

    always_comb
    begin
        accept  = 1'b0;
        do_push = 1'b0;
        do_pop  = 1'b0;
        if (req_new)
        begin
            case (sel)
                SEL_PUSH:
                begin
                    // Waits on a full cache or a transfer
                    accept  = !ctrl_en_reg || !csr_req.write
                            || (fill_reg != FULL_FILL && !cfg_busy);        // see [RULE18]
                    do_push = accept && ctrl_en_reg && csr_req.write;
                end
                SEL_POP:
                begin
                    // Empty cache waits for its refill; popping spill entries waits
                    accept = !ctrl_en_reg || csr_req.write || underflow
                           || ((fill_reg != '0)
                               && !(state_reg == XFER_SPILL
                                    && fill_reg <= FW'(count_reg)));        // see [RULE18]
                    do_pop = accept && ctrl_en_reg && !csr_req.write && fill_reg != '0;
                end
                SEL_NONE: accept = 1'b1;
                default:  accept = !cfg_busy;                               // see [RULE13]
            endcase
        end
    end

    always_comb
    begin
        fill_next = fill_reg;
        if (do_push)
        begin
            fill_next = fill_next + FW'(1);
        end
        if (do_pop)
        begin
            fill_next = fill_next - FW'(1);
        end
        if (refill_done)
        begin
            fill_next = fill_next + FW'(count_reg);
        end
        if (spill_done)
        begin
            fill_next = fill_next - FW'(count_reg);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // CSR answers

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            ack_reg   <= 1'b0;
            err_reg   <= 1'b0;
            rdata_reg <= RESET_DATA;
        end
        else
        begin
            ack_reg <= accept;
            if (accept)
            begin
                err_reg   <= (sel == SEL_NONE);
                rdata_reg <= RESET_DATA;
                case (sel)
                    SEL_CONTROL:
                    begin
                        rdata_reg[CTRL_FILL_MSB:CTRL_FILL_LSB] <=
                            (CTRL_FILL_MSB - CTRL_FILL_LSB + 1)'(fill_reg); // see [RULE4]
                        rdata_reg[CTRL_EN_BIT] <= ctrl_en_reg;
                    end
                    SEL_START:   rdata_reg <= start_reg;                   // see [RULE5]
                    SEL_POINTER: rdata_reg <= pointer_reg;                 // see [RULE6]
                    SEL_LIMIT:   rdata_reg <= limit_reg;                   // see [RULE7]
                    SEL_POP:
                    begin
                        if (do_pop)
                        begin
                            rdata_reg <= cache_mem[top_idx];               // see [RULE2]
                        end
                    end
                    default:     rdata_reg <= RESET_DATA;
                endcase
            end
        end
    end

    assign csr_ready = ack_reg;
    assign csr_error = err_reg;
    assign csr_rdata = rdata_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Configuration registers

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            ctrl_en_reg <= 1'b0;
            flush_reg   <= 1'b0;
            start_reg   <= RESET_ADDR;
            limit_reg   <= RESET_ADDR;
        end
        else
        begin
            if (accept && csr_req.write && sel == SEL_CONTROL)
            begin
                // Only the enable bit is writable
                ctrl_en_reg <= csr_req.wdata[CTRL_EN_BIT];                 // see [RULE4]
                if (ctrl_en_reg && !csr_req.wdata[CTRL_EN_BIT] && fill_reg != '0)
                begin
                    flush_reg <= 1'b1;                                     // see [RULE3]
                end
            end
            else if (flush_reg && fill_reg == '0 && state_reg == XFER_IDLE)
            begin
                flush_reg <= 1'b0;
            end
            if (accept && csr_req.write && sel == SEL_START)
            begin
                start_reg <= csr_req.wdata;                                // see [RULE5]
            end
            if (accept && csr_req.write && sel == SEL_LIMIT)
            begin
                limit_reg <= csr_req.wdata;                                // see [RULE7]
            end
        end
    end

    // Memory top pointer follows each finished burst
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            pointer_reg <= RESET_ADDR;
        end
        else if (accept && csr_req.write && sel == SEL_POINTER)
        begin
            pointer_reg <= csr_req.wdata;                                  // see [RULE6]
        end
        else if (spill_done)
        begin
            pointer_reg <= pointer_reg + bytes_of(count_reg);              // see [RULE15]
        end
        else if (refill_done)
        begin
            pointer_reg <= pointer_reg - bytes_of(count_reg);              // see [RULE15]
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Top-of-stack cache

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            fill_reg <= '0;
            bot_reg  <= '0;
        end
        else
        begin
            fill_reg <= fill_next;                                         // see [RULE12]
            if (spill_done)
            begin
                bot_reg <= bot_reg + IW'(count_reg);
            end
            else if (refill_done)
            begin
                bot_reg <= bot_reg - IW'(count_reg);
            end
        end
    end

    // Storage has no reset; the fill count says what is valid
    always_ff @(posedge ref_clk)
    begin
        if (do_push)
        begin
            cache_mem[push_idx] <= csr_req.wdata;                          // see [RULE1]
        end
        if (mem_ack && mem_valid_reg && state_reg == XFER_REFILL)
        begin
            cache_mem[bot_reg - IW'(count_reg) + IW'(beat_reg)] <= mem_rdata;  // see [RULE9]
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Memory transfers, one beat in flight at a time

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            state_reg     <= XFER_IDLE;
            beat_reg      <= '0;
            count_reg     <= '0;
            mem_valid_reg <= 1'b0;
            mem_req_reg   <= '0;
        end
        else
        begin
            case (state_reg)
                XFER_IDLE:
                begin
                    beat_reg <= '0;
                    if (spill_start)
                    begin
                        state_reg         <= XFER_SPILL;                   // see [RULE8]
                        count_reg         <= start_count;
                        mem_valid_reg     <= 1'b1;
                        mem_req_reg.write <= 1'b1;
                        mem_req_reg.addr  <= pointer_reg;                  // see [RULE15]
                        mem_req_reg.wdata <= cache_mem[bot_reg];
                        mem_req_reg.last  <= (start_count == BW'(1));
                    end
                    else if (refill_start)
                    begin
                        state_reg         <= XFER_REFILL;                  // see [RULE8]
                        count_reg         <= start_count;
                        mem_valid_reg     <= 1'b1;
                        mem_req_reg.write <= 1'b0;
                        mem_req_reg.addr  <= pointer_reg - bytes_of(start_count);
                        mem_req_reg.wdata <= RESET_DATA;
                        mem_req_reg.last  <= (start_count == BW'(1));
                    end
                end
                XFER_SPILL, XFER_REFILL:
                begin
                    if (xfer_last)
                    begin
                        state_reg     <= XFER_IDLE;
                        mem_valid_reg <= 1'b0;                             // see [RULE14]
                    end
                    else if (mem_ack)
                    begin
                        // Next beat only after the previous one is answered
                        beat_reg          <= beat_reg + BW'(1);            // see [RULE14]
                        mem_req_reg.addr  <= mem_req_reg.addr + WORD_BYTES;
                        mem_req_reg.wdata <= (state_reg == XFER_SPILL)
                            ? cache_mem[bot_reg + IW'(beat_reg) + IW'(1)] : RESET_DATA;
                        mem_req_reg.last  <= (beat_reg + BW'(2) == count_reg);
                    end
                end
                default:
                begin
                    state_reg     <= XFER_IDLE;
                    mem_valid_reg <= 1'b0;
                end
            endcase
        end
    end

    assign mem_valid = mem_valid_reg;
    assign mem_req   = mem_req_reg;

endmodule : csr_hardware_stack_cache

// >>> tb/stack_cache_chk.sv
// Port assertions for the hardware stack cache
`timescale 1ns/1ps

module stack_cache_chk
    import hwstack_pkg::*;
#(
    parameter int unsigned STACK_SIZE       = 16,
    parameter int unsigned STACK_BURST_SIZE = 4
)(
    // Clock and reset
    input wire logic            ref_clk,
    input wire logic            resetn,
    // CSR port
    input wire logic            csr_valid,
    input wire csr_req_type     csr_req,
    input wire logic            csr_ready,
    input wire logic            csr_error,
    input wire logic [XLEN-1:0] csr_rdata,
    // Memory port
    input wire logic            mem_valid,
    input wire mem_req_type     mem_req,
    input wire logic            mem_ack,
    input wire logic [XLEN-1:0] mem_rdata
);
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (!resetn);

    logic [7:0] beat_cnt_reg;
    logic       unmapped;

    assign unmapped = csr_req.addr < CSR_STACK_CONTROL || csr_req.addr > CSR_POP_PORT;

    // Beats completed so far in the running burst
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            beat_cnt_reg <= 8'h00;
        else if (mem_valid && mem_ack)
            beat_cnt_reg <= mem_req.last ? 8'h00 : beat_cnt_reg + 8'h01;
    end

    AST_READY_PULSE: assert property (csr_ready |=> !csr_ready)
        else $error("csr_ready longer than one cycle");
    AST_ANSWER_BOUND: assert property (csr_valid && !csr_ready
        |-> ##[1:400] csr_ready) else $error("csr request never answered");
    AST_UNMAPPED: assert property (csr_valid && !csr_ready && unmapped
        |=> csr_ready && csr_error) else $error("unmapped csr not answered with error");
    AST_CTRL_LOW: assert property ((csr_valid && !csr_ready && !csr_req.write
        && csr_req.addr == CSR_STACK_CONTROL) ##1 csr_ready |-> csr_rdata[7:1] == 7'h00)
        else $error("control bits 7:1 not zero");
    AST_MEM_HOLD: assert property (mem_valid && !mem_ack
        |=> mem_valid && $stable(mem_req)) else $error("memory beat changed before ack");
    AST_MEM_STEP: assert property (mem_valid && mem_ack && !mem_req.last
        |=> mem_valid && mem_req.write == $past(mem_req.write)
        && mem_req.addr == $past(mem_req.addr) + WORD_BYTES)
        else $error("burst address not stepped");
    AST_LAST_DROP: assert property (mem_valid && mem_ack && mem_req.last
        |=> !mem_valid) else $error("mem_valid kept after last beat");
    AST_BURST_LEN: assert property (mem_valid && mem_ack
        |-> beat_cnt_reg < STACK_BURST_SIZE) else $error("burst longer than burst size");

    COV_SPILL: cover property (mem_valid && mem_ack && mem_req.write && mem_req.last);
    COV_REFILL: cover property (mem_valid && mem_ack && !mem_req.write && mem_req.last);
    COV_ERROR: cover property (csr_ready && csr_error);
endmodule : stack_cache_chk

bind csr_hardware_stack_cache stack_cache_chk #(
    .STACK_SIZE(STACK_SIZE), .STACK_BURST_SIZE(STACK_BURST_SIZE)
) chk_u (
    .ref_clk(ref_clk), .resetn(resetn), .csr_valid(csr_valid), .csr_req(csr_req),
    .csr_ready(csr_ready), .csr_error(csr_error), .csr_rdata(csr_rdata),
    .mem_valid(mem_valid), .mem_req(mem_req), .mem_ack(mem_ack), .mem_rdata(mem_rdata)
);

// >>> tb/stack_mem_model.sv
// Main memory model answering one beat at a time after a chosen delay
`timescale 1ns/1ps

module stack_mem_model
    import hwstack_pkg::*;
(
    // Clock and reset
    input wire logic            ref_clk,
    input wire logic            resetn,
    // Memory port
    input wire logic            mem_valid,
    input wire mem_req_type     mem_req,
    output logic                mem_ack,
    output logic [XLEN-1:0]     mem_rdata,
    // Answer delay in cycles
    input wire logic [1:0]      ack_delay
);
    logic [XLEN-1:0] word_mem [0:255];
    logic [1:0]      wait_reg;

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            mem_ack   <= 1'b0;
            mem_rdata <= 32'h0000_0000;
            wait_reg  <= 2'b00;
        end
        else if (mem_ack || !mem_valid)
        begin
            // Released data lines never keep the last word
            mem_ack   <= 1'b0;
            mem_rdata <= ~mem_rdata;
            wait_reg  <= 2'b00;
        end
        else if (wait_reg == ack_delay)
        begin
            mem_ack <= 1'b1;
            if (mem_req.write)
                word_mem[mem_req.addr[9:2]] <= mem_req.wdata;
            else
                mem_rdata <= word_mem[mem_req.addr[9:2]];
        end
        else
            wait_reg <= wait_reg + 2'b01;
    end
endmodule : stack_mem_model

// >>> tb/tb_csr_hardware_stack_cache.sv
// Self-checking bench for the hardware stack cache
`timescale 1ns/1ps

module tb_csr_hardware_stack_cache
    import hwstack_pkg::*;
;
    localparam int unsigned SZ    = 4;
    localparam int unsigned BURST = 2;
    typedef struct {logic [XLEN-1:0] rd; logic err; logic chk;} note_type;

    logic            ref_clk = 1'b0;
    logic            resetn;
    logic            csr_valid;
    csr_req_type     csr_req;
    logic            csr_ready;
    logic            csr_error;
    logic [XLEN-1:0] csr_rdata;
    logic            mem_valid;
    mem_req_type     mem_req;
    logic            mem_ack;
    logic [XLEN-1:0] mem_rdata;
    logic [1:0]      ack_delay;
    logic [31:0]     rng = 32'h0000_0019;
    note_type        notes[$];
    note_type        cur;
    logic [XLEN-1:0] model[$];
    logic [XLEN-1:0] saved[$];
    int              num_errors = 0;
    int              n_checks = 0;

    always #4 ref_clk = ~ref_clk;

    csr_hardware_stack_cache #(.STACK_SIZE(SZ), .STACK_BURST_SIZE(BURST)) dut_u (
        .ref_clk(ref_clk), .resetn(resetn), .csr_valid(csr_valid), .csr_req(csr_req),
        .csr_ready(csr_ready), .csr_error(csr_error), .csr_rdata(csr_rdata),
        .mem_valid(mem_valid), .mem_req(mem_req), .mem_ack(mem_ack), .mem_rdata(mem_rdata)
    );
    stack_mem_model mem_u (
        .ref_clk(ref_clk), .resetn(resetn), .mem_valid(mem_valid), .mem_req(mem_req),
        .mem_ack(mem_ack), .mem_rdata(mem_rdata), .ack_delay(ack_delay)
    );

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] next_rand();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng;
    endfunction : next_rand

    task automatic check(input string what, input logic [XLEN-1:0] seen,
                         input logic [XLEN-1:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic summarize();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : summarize

    // One CSR access held until answered; the expected answer is queued
    task automatic csr_io(input logic wr, input logic [CSR_AW-1:0] a, input logic [XLEN-1:0] d,
                          input logic [XLEN-1:0] exp, input logic err, input logic chk);
        int n = 0;
        notes.push_back('{exp, err, chk});
        csr_valid <= 1'b1;
        csr_req   <= '{wr, a, d};
        do
        begin
            @(posedge ref_clk);
            n++;
        end
        while (csr_ready !== 1'b1 && n < 500);
        csr_valid <= 1'b0;
        if (n >= 500)
            check("csr answer", 32'h0000_0000, 32'h0000_0001);
        @(posedge ref_clk);
    endtask : csr_io

    task automatic cw(input logic [CSR_AW-1:0] a, input logic [XLEN-1:0] d);
        csr_io(1'b1, a, d, RESET_DATA, 1'b0, 1'b0);
    endtask : cw

    task automatic cr(input logic [CSR_AW-1:0] a, input logic [XLEN-1:0] e);
        csr_io(1'b0, a, RESET_DATA, e, 1'b0, 1'b1);
    endtask : cr

    task automatic do_push();
        logic [XLEN-1:0] d;
        d = next_rand();
        ack_delay <= d[1:0];
        model.push_back(d);
        cw(CSR_PUSH_PORT, d);
    endtask : do_push

    task automatic do_pop();
        cr(CSR_POP_PORT, model.pop_back());
    endtask : do_pop

    task automatic setup(input logic [XLEN-1:0] s, input logic [XLEN-1:0] p,
                         input logic [XLEN-1:0] l);
        cw(CSR_STACK_REGION_START, s);
        cw(CSR_STACK_TOP_POINTER, p);
        cw(CSR_STACK_REGION_LIMIT, l);
        cw(CSR_STACK_CONTROL, 32'hffff_ffff);
    endtask : setup

    ////////////////////////////////////////////////////////////////////////////////
    // Answer watcher
    always @(posedge ref_clk)
    begin
        if (csr_ready === 1'b1)
        begin
            if (notes.size() == 0)
                check("note queue", 32'h0000_0001, 32'h0000_0000);
            else
            begin
                cur = notes.pop_front();
                check("csr_error", {31'h0, csr_error}, {31'h0, cur.err});
                if (cur.chk)
                    check("csr_rdata", csr_rdata, cur.rd);
            end
        end
    end

    initial
    begin
        repeat (20000) @(posedge ref_clk);
        check("watchdog", 32'h0000_0001, 32'h0000_0000);
        summarize();
    end

    initial
    begin
        resetn    = 1'b0;
        csr_valid = 1'b0;
        csr_req   = '0;
        ack_delay = 2'b00;
        repeat (3) @(posedge ref_clk);
        resetn <= 1'b1;
        @(posedge ref_clk);
        cr(CSR_STACK_CONTROL, RESET_DATA);
        cr(CSR_STACK_REGION_START, RESET_ADDR);
        cr(CSR_STACK_TOP_POINTER, RESET_ADDR);
        cr(CSR_STACK_REGION_LIMIT, RESET_ADDR);
        cr(CSR_POP_PORT, RESET_DATA);
        csr_io(1'b0, 12'h7cf, RESET_DATA, RESET_DATA, 1'b1, 1'b1);
        setup(32'h0000_0100, 32'h0000_0100, 32'h0000_0200);
        cr(CSR_STACK_REGION_START, 32'h0000_0100);
        cr(CSR_STACK_REGION_LIMIT, 32'h0000_0200);
        cr(CSR_STACK_CONTROL, 32'h0000_0001);
        repeat (3) do_push();
        cr(CSR_STACK_CONTROL, 32'h0000_0301);
        do_push();
        cr(CSR_STACK_CONTROL, 32'h0000_0201);
        cr(CSR_STACK_TOP_POINTER, 32'h0000_0108);
        repeat (2) do_pop();
        repeat (10) do_push();
        repeat (12) do_pop();
        cr(CSR_POP_PORT, RESET_DATA);
        cr(CSR_STACK_TOP_POINTER, 32'h0000_0100);
        repeat (5) do_push();
        cw(CSR_STACK_CONTROL, RESET_DATA);
        cr(CSR_STACK_CONTROL, RESET_DATA);
        cr(CSR_STACK_TOP_POINTER, 32'h0000_0114);
        saved = model;
        model.delete();
        setup(32'h0000_0300, 32'h0000_0300, 32'h0000_03f0);
        repeat (6) do_push();
        repeat (6) do_pop();
        cw(CSR_STACK_CONTROL, RESET_DATA);
        setup(32'h0000_0100, 32'h0000_0114, 32'h0000_0200);
        model = saved;
        repeat (5) do_pop();
        repeat (4) @(posedge ref_clk);
        summarize();
    end
endmodule : tb_csr_hardware_stack_cache
